// file: src/curtain_pkg.sv
// Constants, register map and display table for the curtain supervisor
package curtain_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam longint unsigned CLK_HZ        = 64'd200_000_000;
	localparam longint unsigned RESET_MIN_MS  = 64'd250;
	localparam longint unsigned RESET_MAX_MS  = 64'd2000;
	localparam longint unsigned POWER_OFF_MS  = 64'd2000;
	localparam longint unsigned FLASH_HALF_MS = 64'd250;
	localparam longint unsigned MS_PER_S      = 64'd1000;
	// Least times round up, longest times round down
	localparam int unsigned RESET_MIN_CYC_DEF =
		32'((CLK_HZ * RESET_MIN_MS + MS_PER_S - 64'd1) / MS_PER_S);
	localparam int unsigned RESET_MAX_CYC_DEF =
		32'((CLK_HZ * RESET_MAX_MS) / MS_PER_S);
	localparam int unsigned POWER_OFF_CYC_DEF =
		32'((CLK_HZ * POWER_OFF_MS + MS_PER_S - 64'd1) / MS_PER_S);
	localparam int unsigned FLASH_HALF_CYC_DEF =
		32'((CLK_HZ * FLASH_HALF_MS) / MS_PER_S);

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CONFIG  = 8'h00;
	localparam logic [7:0] ADDR_COMMAND = 8'h04;
	localparam logic [7:0] ADDR_STATUS  = 8'h08;
	localparam logic [7:0] ADDR_BLANK   = 8'h0c;
	localparam int CFG_LATCH     = 0;
	localparam int CFG_REDUCED   = 1;
	localparam int CFG_INVERT    = 2;
	localparam int CFG_TEACH_A   = 3;
	localparam int CFG_TEACH_B   = 4;
	localparam int CFG_SHOW_CFG  = 5;
	localparam int CFG_PAIRS_LO  = 6;
	localparam int CFG_PAIRS_HI  = 8;
	localparam int CFG_CASCADE   = 9;
	localparam int CFG_LAST      = 10;
	localparam int CFG_WIDTH     = 11;
	localparam int CMD_TEACH     = 0;
	localparam logic [CFG_WIDTH-1:0] CFG_RESET = 11'h040;
	localparam int ST_STATE_LO   = 0;
	localparam int ST_OSSD       = 4;
	localparam int ST_CODE_LO    = 8;
	localparam int ST_COUNT_LO   = 16;

	// ------------------------------------------------------------
	// Limits and codes
	// ------------------------------------------------------------
	localparam logic [2:0] MAX_PAIRS  = 3'h4;
	localparam logic [2:0] ONE_PAIR   = 3'h1;
	localparam logic [3:0] ERR_BLANK  = 4'h6;
	localparam logic [3:0] ERR_CASC   = 4'h7;
	localparam logic [3:0] DIGIT_MAX  = 4'h9;
	localparam int NUM_ZONES = 8;

	typedef enum logic [2:0] {
		ST_POWERUP, ST_WAIT_RESET, ST_RUN, ST_BLOCKED, ST_LOCKOUT
	} sup_state_t;

	// Segments ordered g f e d c b a
	function automatic logic [6:0] seg_of(input logic [3:0] d);
		unique case (d)
			4'h0: seg_of = 7'h3f;
			4'h1: seg_of = 7'h06;
			4'h2: seg_of = 7'h5b;
			4'h3: seg_of = 7'h4f;
			4'h4: seg_of = 7'h66;
			4'h5: seg_of = 7'h6d;
			4'h6: seg_of = 7'h7d;
			4'h7: seg_of = 7'h07;
			4'h8: seg_of = 7'h7f;
			4'h9: seg_of = 7'h6f;
			4'ha: seg_of = 7'h77;
			4'hb: seg_of = 7'h7c;
			4'hc: seg_of = 7'h39;
			4'hd: seg_of = 7'h5e;
			4'he: seg_of = 7'h79;
			4'hf: seg_of = 7'h71;
		endcase
	endfunction : seg_of
endpackage : curtain_pkg

// file: src/curtain_supervisor.sv
// Reset, lockout and indicator supervisor of a safety light curtain
// Overview of operation
// - Yellow lamp steady in run, flashing awaiting reset
// - Status flashes green with reduced resolution
// - Status green outputs on, red outputs off
// - Red status flashes in lockout, both units
// - First zone lamp also shows sync status
// - Digit shows error, configuration or blocked count
// - Emitter lamp shows power, test, lockout
// - Manual reset leaves the latch wait (entered after power-up in latch mode) and lockout
// - Only open-closed-open sequence counts as reset, with the synchronised switch's reset value as the first open
// - Lockout forces outputs off until valid reset or, in trip mode, a long power cycle
// - Lockout shows numeric error code
// - Trip mode: long power cycle clears lockout
// - Blanked beam clearing causes lockout
// - Two switches plus reset teach blanking
// - Configuration bit inverts seven-segment display
// - Cascade limited to four pairs
// - Remote teach only in cascade mode, as single pair or last receiver
// - Trip auto-start; latch needs reset
// - Reduced resolution tolerates two adjacent beams
`timescale 1ns/1ps
module curtain_supervisor #(
	parameter int          NUM_BEAMS      = 16,
	parameter int unsigned RESET_MIN_CYC  = curtain_pkg::RESET_MIN_CYC_DEF,
	parameter int unsigned RESET_MAX_CYC  = curtain_pkg::RESET_MAX_CYC_DEF,
	parameter int unsigned POWER_OFF_CYC  = curtain_pkg::POWER_OFF_CYC_DEF,
	parameter int unsigned FLASH_HALF_CYC = curtain_pkg::FLASH_HALF_CYC_DEF
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// Register port
	input  wire logic [7:0]           addr,
	input  wire logic [31:0]          wdata,
	input  wire logic                 wstrobe,
	input  wire logic                 rstrobe,
	output logic      [31:0]          rdata,
	// Pins
	input  wire logic                 reset_sw_closed,
	input  wire logic                 power_good,
	input  wire logic                 emitter_test,
	// Scanner, same clock
	input  wire logic [NUM_BEAMS-1:0] beam_blocked,
	input  wire logic                 sync_ok,
	input  wire logic                 self_test_ok,
	input  wire logic                 fault,
	input  wire logic [3:0]           fault_code,
	// Safety outputs
	output logic                      ossd_a,
	output logic                      ossd_b,
	// Indicators
	output logic                      reset_lamp,
	output logic                      status_green,
	output logic                      status_red,
	output logic                      emitter_green,
	output logic                      emitter_red,
	output logic [curtain_pkg::NUM_ZONES-1:0] zone_green,
	output logic [curtain_pkg::NUM_ZONES-1:0] zone_red,
	output logic [6:0]                segments
);
	import curtain_pkg::*;
	localparam int ZW = NUM_BEAMS / NUM_ZONES;
	localparam int CW = $clog2(NUM_BEAMS + 1);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
		end else begin
			pin_meta <= {emitter_test, power_good, reset_sw_closed};
			pin_sync <= pin_meta;
		end
	end
	wire sw_s   = pin_sync[0];
	wire pwr_s  = pin_sync[1];
	wire test_s = pin_sync[2];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [CFG_WIDTH-1:0] cfg;
	logic [NUM_BEAMS-1:0] blank_mask;
	logic [3:0]           lock_code;
	sup_state_t           state;
	sup_state_t           next_state;
	wire wr_cfg   = wstrobe && (addr == ADDR_CONFIG);
	wire wr_cmd   = wstrobe && (addr == ADDR_COMMAND);
	wire latch_md = cfg[CFG_LATCH];
	wire reduced  = cfg[CFG_REDUCED];
	wire [2:0] pairs = cfg[CFG_PAIRS_HI:CFG_PAIRS_LO];
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			cfg <= CFG_RESET;
		else if (wr_cfg)
			cfg <= wdata[CFG_WIDTH-1:0];
	end

	// ------------------------------------------------------------
	// Monitored reset switch
	// ------------------------------------------------------------
	// Armed once the synchronised switch reads open, which its reset value
	// does, so a switch closed from power-up can still time a valid closure.
	logic        armed;
	logic        sw_prev;
	logic [31:0] hold;
	wire [31:0] next_hold = (hold > RESET_MAX_CYC) ? hold : hold + 32'h1;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			armed   <= 1'b0;
			sw_prev <= 1'b0;
			hold    <= 32'h0;
		end else begin
			sw_prev <= sw_s;
			if (!sw_s) begin
				armed <= 1'b1;
				hold  <= 32'h0;
			end else if (armed)
				hold <= next_hold;
		end
	end
	wire release_edge = sw_prev && !sw_s && armed;
	wire reset_ok = release_edge && (hold >= RESET_MIN_CYC) &&
		(hold <= RESET_MAX_CYC);

	// ------------------------------------------------------------
	// Power cycle detection
	// ------------------------------------------------------------
	logic [31:0] off_cnt;
	logic        pwr_prev;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			off_cnt  <= 32'h0;
			pwr_prev <= 1'b0;
		end else begin
			pwr_prev <= pwr_s;
			if (pwr_s)
				off_cnt <= 32'h0;
			else if (off_cnt <= POWER_OFF_CYC)
				off_cnt <= off_cnt + 32'h1;
		end
	end
	wire long_cycle = pwr_s && !pwr_prev &&
		(off_cnt > POWER_OFF_CYC);

	// ------------------------------------------------------------
	// Beam evaluation
	// ------------------------------------------------------------
	wire [NUM_BEAMS-1:0] eff = beam_blocked & ~blank_mask;
	wire blank_moved = |(blank_mask & ~beam_blocked);
	logic [CW-1:0] blk_cnt;
	always_comb begin
		blk_cnt = '0;
		for (int i = 0; i < NUM_BEAMS; i++)
			blk_cnt = blk_cnt + CW'(eff[i]);
	end
	logic [NUM_BEAMS-2:0] adj;
	genvar g;
	generate
		for (g = 0; g < NUM_BEAMS - 1; g++) begin : g_adj
			assign adj[g] = eff[g] && eff[g+1];
		end
	endgenerate
	// Beam 0 carries sync and is never tolerated
	wire tolerated = !eff[0] && ((blk_cnt == CW'(0)) ||
		(blk_cnt == CW'(1)) || ((blk_cnt == CW'(2)) && |adj));
	wire tripped = reduced ? !tolerated : |eff;

	// Cascade and remote teach
	wire casc_bad = cfg[CFG_CASCADE] ? ((pairs == 3'h0) ||
		(pairs > MAX_PAIRS)) : (pairs != ONE_PAIR);
	wire remote_ok = cfg[CFG_CASCADE] &&
		(cfg[CFG_LAST] || pairs == ONE_PAIR);
	wire remote_teach = wr_cmd && wdata[CMD_TEACH] && remote_ok;
	wire local_teach = reset_ok && cfg[CFG_TEACH_A] &&
		cfg[CFG_TEACH_B];
	wire teach = (local_teach || remote_teach) && (state != ST_RUN);
	wire lock_now = fault || blank_moved || casc_bad;
	wire fault_gone = !lock_now && self_test_ok;

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			blank_mask <= '0;
		else if (teach)
			blank_mask <= beam_blocked;
	end

	// ------------------------------------------------------------
	// Supervisor state machine
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			ST_POWERUP:
				if (self_test_ok && sync_ok && !tripped)
					next_state = latch_md ? ST_WAIT_RESET : ST_RUN;
			ST_WAIT_RESET:
				if (reset_ok && !tripped)
					next_state = ST_RUN;
			ST_RUN:
				if (tripped || !sync_ok)
					next_state = latch_md ? ST_WAIT_RESET
						: ST_BLOCKED;
			ST_BLOCKED:
				if (!tripped && sync_ok)
					next_state = ST_RUN;
			ST_LOCKOUT:
				if (fault_gone && reset_ok)
					next_state = tripped ? (latch_md ? ST_WAIT_RESET
						: ST_BLOCKED) : ST_RUN;
				else if (!latch_md && long_cycle && !lock_now)
					next_state = ST_POWERUP;
		endcase
		if (teach)
			next_state = ST_POWERUP;
		if (lock_now && !teach)
			next_state = ST_LOCKOUT;
		else if (!pwr_s && state != ST_LOCKOUT)
			next_state = ST_POWERUP;
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state     <= ST_POWERUP;
			lock_code <= 4'h0;
		end else begin
			state <= next_state;
			if (lock_now && state != ST_LOCKOUT)
				lock_code <= fault ? fault_code : blank_moved ?
					ERR_BLANK : ERR_CASC;
		end
	end
	wire run    = (state == ST_RUN) && pwr_s;
	wire locked = (state == ST_LOCKOUT);

	// ------------------------------------------------------------
	// Flash timebase
	// ------------------------------------------------------------
	// One free-running flash phase keeps every lamp blinking in step
	logic [31:0] flash_cnt;
	logic        flash;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flash_cnt <= 32'h0;
			flash     <= 1'b0;
		end else if (flash_cnt >= FLASH_HALF_CYC - 32'h1) begin
			flash_cnt <= 32'h0;
			flash     <= !flash;
		end else
			flash_cnt <= flash_cnt + 32'h1;
	end

	// ------------------------------------------------------------
	// Lamps and display
	// ------------------------------------------------------------
	wire next_status_red = locked ? flash : !run;
	wire next_status_green = !locked && run &&
		(reduced ? flash : 1'b1);
	wire next_reset_lamp = run ? 1'b1 :
		(state == ST_WAIT_RESET) ? flash : 1'b0;
	wire next_em_red = pwr_s && (locked ? flash : test_s);
	wire next_em_green = pwr_s && !locked && !test_s;
	wire [3:0] cnt_digit = (blk_cnt > CW'(DIGIT_MAX)) ? DIGIT_MAX :
		4'(blk_cnt);
	wire [3:0] digit = locked ? lock_code :
		cfg[CFG_SHOW_CFG] ? {1'b0, pairs} : cnt_digit;
	wire [6:0] seg_up = seg_of(digit);
	wire [6:0] seg_inv = {seg_up[6], seg_up[2], seg_up[1], seg_up[0],
		seg_up[5], seg_up[4], seg_up[3]};
	wire [6:0] next_segments = cfg[CFG_INVERT] ? seg_inv : seg_up;

	logic [NUM_ZONES-1:0] next_zg;
	logic [NUM_ZONES-1:0] next_zr;
	generate
		for (g = 0; g < NUM_ZONES; g++) begin : g_zone
			wire z_blk = |eff[g*ZW +: ZW];
			wire z_bl  = |blank_mask[g*ZW +: ZW];
			wire z_sync = (g == 0) ? sync_ok : 1'b1;
			assign next_zr[g] = z_blk || !z_sync;
			assign next_zg[g] = !next_zr[g] &&
				(z_bl ? flash : 1'b1);
		end
	endgenerate

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ossd_a        <= 1'b0;
			ossd_b        <= 1'b0;
			reset_lamp    <= 1'b0;
			status_green  <= 1'b0;
			status_red    <= 1'b0;
			emitter_green <= 1'b0;
			emitter_red   <= 1'b0;
			zone_green    <= '0;
			zone_red      <= '0;
			segments      <= 7'h00;
		end else begin
			ossd_a        <= run;
			ossd_b        <= run;
			reset_lamp    <= next_reset_lamp;
			status_green  <= next_status_green;
			status_red    <= next_status_red;
			emitter_green <= next_em_green;
			emitter_red   <= next_em_red;
			zone_green    <= next_zg;
			zone_red      <= next_zr;
			segments      <= next_segments;
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	logic [31:0] status_word;
	always_comb begin
		status_word = 32'h0;
		status_word[ST_STATE_LO +: 3] = state;
		status_word[ST_OSSD] = ossd_a;
		status_word[ST_CODE_LO +: 4] = lock_code;
		status_word[ST_COUNT_LO +: CW] = blk_cnt;
	end
	wire [31:0] read_mux =
		(addr == ADDR_CONFIG) ? 32'(cfg) :
		(addr == ADDR_STATUS) ? status_word :
		(addr == ADDR_BLANK)  ? 32'(blank_mask) : 32'h0;
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rdata <= 32'h0;
		else
			rdata <= rstrobe ? read_mux : 32'h0;
	end
endmodule : curtain_supervisor

// file: bench/curtain_supervisor_assertions.sv
// Port-level checker for the curtain supervisor
`timescale 1ns/1ps
module curtain_supervisor_assertions (
	// Clock and reset
	input wire logic       clk,
	input wire logic       reset,
	// Pins and scanner
	input wire logic       power_good,
	input wire logic       emitter_test,
	input wire logic       sync_ok,
	// Outputs
	input wire logic       ossd_a,
	input wire logic       ossd_b,
	input wire logic       reset_lamp,
	input wire logic       status_green,
	input wire logic       status_red,
	input wire logic       emitter_green,
	input wire logic       emitter_red,
	input wire logic [curtain_pkg::NUM_ZONES-1:0] zone_green,
	input wire logic [curtain_pkg::NUM_ZONES-1:0] zone_red
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	ossd_pair_a: assert property (ossd_a == ossd_b)
		else $error("safety channels differ");
	on_lamps_a: assert property (ossd_a |->
		!status_red && reset_lamp)
		else $error("lamps wrong while outputs on");
	lamp_excl_a: assert property (!(status_green && status_red))
		else $error("status red and green together");
	zone_excl_a: assert property ((zone_green & zone_red) == '0)
		else $error("zone red and green together");
	sync_zone_a: assert property (!sync_ok |=> zone_red[0])
		else $error("first zone hides lost sync");
	power_off_a: assert property (!power_good [*4] |=> !ossd_a)
		else $error("outputs on without power");
	emitter_dark_a: assert property (!power_good [*4] |=>
		!emitter_green && !emitter_red)
		else $error("emitter lamp lit without power");
	test_red_a: assert property (
		(emitter_test && power_good) [*4] |=> !emitter_green)
		else $error("emitter green in test");
endmodule : curtain_supervisor_assertions

bind curtain_supervisor curtain_supervisor_assertions u_chk (.clk, .reset,
	.power_good, .emitter_test, .sync_ok, .ossd_a, .ossd_b, .reset_lamp,
	.status_green, .status_red, .emitter_green, .emitter_red, .zone_green,
	.zone_red);

// file: bench/reset_switch_model.sv
// Operator reset switch: one closure of a chosen length per request
`timescale 1ns/1ps
module reset_switch_model (
	// Clock
	input  wire logic        clk,
	// Request
	input  wire logic        go,
	input  wire logic [31:0] hold,
	// Contact
	output logic             reset_sw_closed,
	output logic             busy
);
	int n = 0;
	// Open, closed for hold cycles, open again
	always @(posedge clk) begin
		if (go)
			n <= hold;
		else if (n != 0)
			n <= n - 1;
	end
	assign reset_sw_closed = (n != 0);
	assign busy = (n != 0);
endmodule : reset_switch_model

// file: bench/curtain_supervisor_bench.sv
// Self-checking bench for the curtain supervisor
`timescale 1ns/1ps
module curtain_supervisor_bench;
	import curtain_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wstrobe = 1'b0;
	logic rstrobe = 1'b0;
	logic power_good = 1'b1;
	logic emitter_test = 1'b0;
	logic [15:0] beam_blocked = 16'h0;
	logic sync_ok = 1'b1;
	logic self_test_ok = 1'b1;
	logic fault = 1'b0;
	logic [3:0] fault_code = 4'h0;
	logic go = 1'b0;
	logic [31:0] hold = 32'h0;
	wire logic [31:0] rdata;
	wire logic ossd_a, ossd_b, reset_lamp, status_green, status_red;
	wire logic emitter_green, emitter_red, reset_sw_closed, busy;
	wire logic [7:0] zone_green, zone_red;
	wire logic [6:0] segments;
	wire logic [4:0] lamps = {zone_green[4], emitter_red, status_red,
		status_green, reset_lamp};
	int fails = 0;
	int tests_run = 0;
	logic [31:0] d;
	always #2.5 clk = ~clk;
	// Short counts keep the run brief
	curtain_supervisor #(.RESET_MIN_CYC(20), .RESET_MAX_CYC(100),
		.POWER_OFF_CYC(50), .FLASH_HALF_CYC(4)) u_dut (.clk, .reset, .addr,
		.wdata, .wstrobe, .rstrobe, .rdata, .reset_sw_closed, .power_good,
		.emitter_test, .beam_blocked, .sync_ok, .self_test_ok, .fault,
		.fault_code, .ossd_a, .ossd_b, .reset_lamp, .status_green,
		.status_red, .emitter_green, .emitter_red, .zone_green, .zone_red,
		.segments);
	reset_switch_model u_sw (.clk, .go, .hold, .reset_sw_closed, .busy);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wstrobe <= 1'b1;
		@(posedge clk);
		wstrobe <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rstrobe <= 1'b1;
		@(posedge clk);
		rstrobe <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic rc(input logic [7:0] a, input string nm, logic [31:0] e);
		rd(a);
		chk(nm, e, d);
	endtask : rc
	// Polls the state field; a lost wait ends the run
	task automatic wst(input logic [2:0] e);
		int i;
		for (i = 0; i < 300; i++) begin
			rd(ADDR_STATUS);
			if (d[2:0] === e)
				break;
		end
		chk("state", e, d[2:0]);
		if (i == 300)
			final_report();
	endtask : wst
	task automatic press(input int n);
		int i;
		@(posedge clk);
		hold <= n;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		#1;
		for (i = 0; i < 200 && busy !== 1'b0; i++)
			@(posedge clk);
		if (i == 200) begin
			fails++;
			final_report();
		end
		repeat (8) @(posedge clk);
	endtask : press
	task automatic flash(input string nm, input int w);
		int i;
		int t;
		logic p;
		t = 0;
		p = lamps[w];
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			#1;
			if (lamps[w] !== p)
				t++;
			p = lamps[w];
		end
		chk(nm, 1, t >= 2);
	endtask : flash
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rc(ADDR_CONFIG, "config", 32'h40);
		rc(8'h10, "unmapped", 32'h0);
		wst(ST_RUN);
		chk("ossd", 1, ossd_a);
		chk("green", 1, status_green);
		chk("yellow", 1, reset_lamp);
		chk("digit", 32'h3f, segments);
		// Lost sync drops the outputs and lights the first zone red
		@(posedge clk) sync_ok <= 1'b0;
		wst(ST_BLOCKED);
		chk("zone", 32'h01, zone_red);
		@(posedge clk) sync_ok <= 1'b1;
		wst(ST_RUN);
		@(posedge clk) beam_blocked <= 16'h0008;
		wst(ST_BLOCKED);
		chk("red", 1, status_red);
		chk("zone", 32'h02, zone_red);
		chk("zone green", 32'hfd, zone_green);
		chk("digit", 32'h06, segments);
		wr(ADDR_CONFIG, 32'h044);
		repeat (3) @(posedge clk);
		#1 chk("invert", 32'h30, segments);
		// Two adjacent beams pass, a gap between them trips
		wr(ADDR_CONFIG, 32'h042);
		@(posedge clk) beam_blocked <= 16'h0060;
		wst(ST_RUN);
		flash("reduced", 1);
		@(posedge clk) beam_blocked <= 16'h00a0;
		wst(ST_BLOCKED);
		@(posedge clk) beam_blocked <= 16'h0000;
		wst(ST_RUN);
		wr(ADDR_CONFIG, 32'h041);
		@(posedge clk) beam_blocked <= 16'h0008;
		wst(ST_WAIT_RESET);
		@(posedge clk) beam_blocked <= 16'h0000;
		flash("waiting", 0);
		press(10);
		wst(ST_WAIT_RESET);
		press(150);
		wst(ST_WAIT_RESET);
		press(50);
		wst(ST_RUN);
		// Fault lockout held until reset after repair
		wr(ADDR_CONFIG, 32'h040);
		@(posedge clk) fault_code <= 4'h5;
		fault <= 1'b1;
		wst(ST_LOCKOUT);
		chk("code", 32'h5, d[11:8]);
		chk("ossd", 0, ossd_b);
		chk("digit", 32'h6d, segments);
		flash("lockout", 2);
		flash("emitter lockout", 3);
		@(posedge clk) fault <= 1'b0;
		repeat (10) @(posedge clk);
		wst(ST_LOCKOUT);
		press(50);
		wst(ST_RUN);
		// A short power loss leaves a lockout, a long one clears it
		@(posedge clk) fault <= 1'b1;
		wst(ST_LOCKOUT);
		@(posedge clk) fault <= 1'b0;
		power_good <= 1'b0;
		repeat (20) @(posedge clk);
		power_good <= 1'b1;
		repeat (10) @(posedge clk);
		wst(ST_LOCKOUT);
		power_good <= 1'b0;
		repeat (60) @(posedge clk);
		power_good <= 1'b1;
		wst(ST_RUN);
		emitter_test <= 1'b1;
		repeat (5) @(posedge clk);
		#1 chk("emitter", 1, emitter_red);
		chk("emitter green", 0, emitter_green);
		emitter_test <= 1'b0;
		repeat (5) @(posedge clk);
		#1 chk("emitter green", 1, emitter_green);
		// Show-configuration digit gives the pair count
		wr(ADDR_CONFIG, 32'h060);
		repeat (3) @(posedge clk);
		#1 chk("config digit", 32'h06, segments);
		// Cascade limit, then teach rights
		wr(ADDR_CONFIG, 32'h340);
		wst(ST_LOCKOUT);
		chk("code", 32'h7, d[11:8]);
		wr(ADDR_CONFIG, 32'h300);
		press(50);
		wst(ST_RUN);
		wr(ADDR_CONFIG, 32'h280);
		@(posedge clk) beam_blocked <= 16'h0200;
		wst(ST_BLOCKED);
		wr(ADDR_COMMAND, 32'h1);
		rc(ADDR_BLANK, "blank", 32'h0);
		wr(ADDR_CONFIG, 32'h680);
		wr(ADDR_COMMAND, 32'h1);
		rc(ADDR_BLANK, "blank", 32'h0200);
		wst(ST_RUN);
		flash("blanked zone", 4);
		@(posedge clk) beam_blocked <= 16'h0000;
		wst(ST_LOCKOUT);
		chk("code", 32'h6, d[11:8]);
		wr(ADDR_CONFIG, 32'h058);
		@(posedge clk) beam_blocked <= 16'h1000;
		press(50);
		rc(ADDR_BLANK, "blank", 32'h1000);
		wst(ST_RUN);
		final_report();
	end
	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		final_report();
	end
endmodule : curtain_supervisor_bench
